// [include/asp_pkg.sv]
// Shared constants of the angle sensor serial slave.
package asp_pkg;
  // Clock and sample timing.
  localparam int unsigned CLK_PERIOD_NS      = 20;
  localparam int unsigned SAMPLE_PERIOD_NS   = 1000;
  localparam int unsigned SAMPLE_CYCLES      = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SSI_TIMEOUT_NS     = 25000;
  localparam int unsigned SSI_TIMEOUT_CYCLES =
    (SSI_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_W             = 6;
  localparam int unsigned SSI_TMO_W          = 11;
  // Data path widths.
  localparam int unsigned ANGLE_W   = 8;
  localparam int unsigned FRAME_W   = 16;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned FILT_SHIFT = 12;
  localparam int unsigned FILT_W    = ANGLE_W + FILT_SHIFT;
  localparam int unsigned CNT_W     = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_SAT  = 5'h1F;
  // Frame fields.
  localparam int unsigned CMD_MSB  = 15;
  localparam int unsigned CMD_LSB  = 13;
  localparam int unsigned ADDR_MSB = 12;
  localparam int unsigned ADDR_LSB = 8;
  localparam logic [2:0] CMD_READ  = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  // Register addresses.
  localparam logic [4:0] REG_ZERO_LO = 5'h00;
  localparam logic [4:0] REG_ZERO_HI = 5'h01;
  localparam logic [4:0] REG_THRESH  = 5'h06;
  localparam logic [4:0] REG_DIR     = 5'h09;
  localparam logic [4:0] REG_FLAGS   = 5'h1B;
  // Field positions inside the registers.
  localparam int unsigned THR_LOW_MSB  = 7;
  localparam int unsigned THR_LOW_LSB  = 5;
  localparam int unsigned THR_HIGH_MSB = 4;
  localparam int unsigned THR_HIGH_LSB = 2;
  localparam int unsigned DIR_BIT      = 7;
  localparam int unsigned FLAG_HI_BIT  = 7;
  localparam int unsigned FLAG_LO_BIT  = 6;
  localparam int unsigned FIELD_MSB    = 7;
  localparam int unsigned FIELD_LSB    = 5;
  // Reset values of the programmable registers.
  localparam logic [15:0] ZERO_RESET     = 16'h0000;
  localparam logic [2:0]  THR_LOW_RESET  = 3'h0;
  localparam logic [2:0]  THR_HIGH_RESET = 3'h7;
  localparam logic        DIR_RESET      = 1'b0;
  // Synchronised pin indices.
  localparam int unsigned PIN_SCLK = 0;
  localparam int unsigned PIN_CS_N = 1;
  localparam int unsigned PIN_MOSI = 2;
  localparam int unsigned PIN_SSCK = 3;
  localparam int unsigned PIN_N    = 4;
  typedef enum logic [0:0] {
    ASP_SSI_IDLE  = 1'b0,
    ASP_SSI_SHIFT = 1'b1
  } asp_ssi_state_type;
endpackage : asp_pkg

// [rtl/asp_pair_buffer.sv]
// Small valid/ready buffer that holds angle samples on their way to the output buffer.
`timescale 1ns/1ps
module asp_pair_buffer #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (count_q != CNT_W'(DEPTH));
  assign out_valid_out = (count_q != '0);
  assign out_data_out  = mem_q[rd_ptr_q];

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    next_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction : next_ptr

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_ptr_q] <= in_data_in;
        wr_ptr_q        <= next_ptr(wr_ptr_q);
      end
      if (pop)
        rd_ptr_q <= next_ptr(rd_ptr_q);
      count_q <= CNT_W'(count_q + CNT_W'(push) - CNT_W'(pop));
    end
  end
endmodule : asp_pair_buffer

// [rtl/asp_angle_slave.sv]
// Angle sensor serial slave: sample conditioning, SPI register access and SSI readout.
`timescale 1ns/1ps
// Operation
// RL1: Accept SPI mode 0 and mode 3, telling them apart without configuration.
// RL2: Serial clock up to 25 MHz, no lower limit and no timeout.
// RL3: Master sends each command as one 16-bit frame.
// RL4: Sample on rising SCLK, change on falling, MSB first, select low.
// RL5: Master keeps select high at least 150 ns between angle frames.
// RL6: Master keeps select high 750 ns around register readout frames.
// RL7: Master waits 20 ms after a write before reading back.
// RL8: A fresh angle sample is produced every microsecond; the filter here skips ticks while the sample buffer is full.
// RL9: Filter (1+2ts)/(1+ts)^2 conditions the angle without steady-state lag.
// RL10: Clockwise rotation counts up by default; direction and zero programmable.
// RL11: Low-field output is set while field lies below low threshold.
// RL12: High-field output is set while field lies above high threshold.
// RL13: Undriven MISO is released and reads low through a pull-down.
// RL14: Angle readable over SPI and SSI; registers reachable only by SPI.
// RL15: Select falling freezes the output buffer until select rises.
// RL16: Command 010 with address; next frame returns register in upper byte.
// RL17: Command 100 writes address; next frame returns the stored value.
// RL18: Unused trailing bit positions of the angle word are zero.
// RL19: New samples enter the output buffer only while select is high.
// RL20: Bit counter restarts on every select falling edge.
module asp_angle_slave (
  input  wire logic                        mclk_in,
  input  wire logic                        reset_in,
  input  wire logic [asp_pkg::ANGLE_W-1:0] raw_angle_in,
  input  wire logic [asp_pkg::ANGLE_W-1:0] field_strength_in,
  input  wire logic                        sclk_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        mosi_in,
  input  wire logic                        ssck_in,
  output logic                             miso_out,
  output logic                             miso_oe_out,
  output logic                             ssd_out,
  output logic                             field_low_flag_out,
  output logic                             field_high_flag_out,
  output logic                             spi_mode3_out
);
  import asp_pkg::*;

  localparam int TICK_GAP = SAMPLE_CYCLES;

  logic [PIN_N-1:0]     pin_meta_q;
  logic [PIN_N-1:0]     pin_sync_q;
  logic [PIN_N-1:0]     pin_prev_q;
  logic [TICK_W-1:0]    div_q;
  logic                 tick_q;
  logic [FILT_W-1:0]    s1_q;
  logic [FILT_W-1:0]    s2_q;
  logic                 seeded_q;
  logic [ANGLE_W-1:0]   obuf_q;
  logic [15:0]          zero_q;
  logic [2:0]           field_low_threshold_q;
  logic [2:0]           field_high_threshold_q;
  logic                 rot_dir_q;
  logic [FRAME_W-1:0]   rx_q;
  logic [FRAME_W-1:0]   tx_q;
  logic [CNT_W-1:0]     bitcnt_q;
  logic [4:0]           reply_addr_q;
  logic                 reply_pend_q;
  logic [7:0]           reg_rd_val;
  asp_ssi_state_type    ssi_state_q;
  logic [FRAME_W-1:0]   ssi_tx_q;
  logic [SSI_TMO_W-1:0] ssi_tmo_q;
  logic                 buf_in_ready;
  logic                 buf_out_valid;
  logic [ANGLE_W-1:0]   buf_out_data;

  // Every pin input passes two flip-flops before any logic looks at it.
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_sync
      always_ff @(posedge mclk_in)
      begin
        pin_meta_q[gi] <= (gi == PIN_SCLK) ? sclk_in : (gi == PIN_CS_N) ? cs_n_in :
                          (gi == PIN_MOSI) ? mosi_in : ssck_in;
        pin_sync_q[gi] <= pin_meta_q[gi];
        pin_prev_q[gi] <= pin_sync_q[gi];
      end
    end
  endgenerate

  wire cs_high    = pin_sync_q[PIN_CS_N];
  wire cs_fall    = !pin_sync_q[PIN_CS_N] && pin_prev_q[PIN_CS_N];
  wire cs_rise    = pin_sync_q[PIN_CS_N] && !pin_prev_q[PIN_CS_N];
  wire sclk_rise  = pin_sync_q[PIN_SCLK] && !pin_prev_q[PIN_SCLK] && !cs_high;
  wire sclk_fall  = !pin_sync_q[PIN_SCLK] && pin_prev_q[PIN_SCLK] && !cs_high;
  wire ssck_rise  = pin_sync_q[PIN_SSCK] && !pin_prev_q[PIN_SSCK];
  wire ssck_fall  = !pin_sync_q[PIN_SSCK] && pin_prev_q[PIN_SSCK];
  wire ssi_busy   = (ssi_state_q == ASP_SSI_SHIFT);

  // Sample-rate enable: one pulse every microsecond.
  wire tick_wrap = (div_q == TICK_W'(SAMPLE_CYCLES - 1));
  always_ff @(posedge mclk_in)
  begin
    div_q  <= (reset_in || tick_wrap) ? '0 : TICK_W'(div_q + 1'b1);
    tick_q <= !reset_in && tick_wrap; // [RL8]
  end

  // Two cascaded first-order stages; 2*s1 - s2 realises the lead-lag response.
  wire step = tick_q && buf_in_ready;
  wire signed [FILT_W+1:0] x_ext  = {2'b00, raw_angle_in, {FILT_SHIFT{1'b0}}};
  wire signed [FILT_W+1:0] s1_ext = {2'b00, s1_q};
  wire signed [FILT_W+1:0] s2_ext = {2'b00, s2_q};
  wire signed [FILT_W+1:0] s1_sum = s1_ext + ((x_ext - s1_ext) >>> FILT_SHIFT);
  wire signed [FILT_W+1:0] s2_sum = s2_ext + ((s1_ext - s2_ext) >>> FILT_SHIFT);
  wire signed [FILT_W+1:0] y_full = (s1_ext <<< 1) - s2_ext; // [RL9]
  wire [ANGLE_W-1:0] y_angle = y_full[FILT_W+1] ? '0 : y_full[FILT_W] ? '1 :
                               y_full[FILT_W-1:FILT_SHIFT];
  wire [15:0] raw16 = {y_angle, {(16 - ANGLE_W){1'b0}}};
  wire [15:0] rel16 = rot_dir_q ? 16'(zero_q - raw16) : 16'(raw16 - zero_q); // [RL10]

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      seeded_q <= 1'b0;
    else if (step)
      seeded_q <= 1'b1;
    if (step)
    begin
      s1_q <= seeded_q ? s1_sum[FILT_W-1:0] : x_ext[FILT_W-1:0];
      s2_q <= seeded_q ? s2_sum[FILT_W-1:0] : x_ext[FILT_W-1:0];
    end
  end

  // Sample buffer drains into the output buffer only while neither port is reading a frame.
  asp_pair_buffer #(
    .WIDTH (ANGLE_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .mclk_in       (mclk_in),
    .reset_in      (reset_in),
    .in_valid_in   (tick_q && seeded_q),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (rel16[15:16-ANGLE_W]),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (cs_high && !ssi_busy),
    .out_data_out  (buf_out_data)
  );

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      obuf_q <= '0;
    else if (buf_out_valid && cs_high && !ssi_busy)
      obuf_q <= buf_out_data; // [RL19] [RL15]
  end

  // Field comparisons.
  wire [2:0] field_top = field_strength_in[FIELD_MSB:FIELD_LSB];
  wire field_low_now   = field_top < field_low_threshold_q;
  wire field_high_now  = field_top > field_high_threshold_q;
  always_ff @(posedge mclk_in)
  begin
    field_low_flag_out  <= !reset_in && field_low_now;  // [RL11]
    field_high_flag_out <= !reset_in && field_high_now; // [RL12]
  end

  // Register decode.
  wire [2:0] rx_cmd   = rx_q[CMD_MSB:CMD_LSB];
  wire [4:0] rx_addr  = rx_q[ADDR_MSB:ADDR_LSB];
  wire       frame_ok = cs_rise && (bitcnt_q == CNT_FULL);
  wire       cmd_wr   = frame_ok && (rx_cmd == CMD_WRITE);
  wire       cmd_rd   = frame_ok && (rx_cmd == CMD_READ);
  wire [7:0] wr_data  = rx_q[7:0];

  always_comb
  begin
    reg_rd_val = '0;
    unique case (reply_addr_q)
      REG_ZERO_LO: reg_rd_val = zero_q[7:0];
      REG_ZERO_HI: reg_rd_val = zero_q[15:8];
      REG_THRESH:  reg_rd_val = {field_low_threshold_q, field_high_threshold_q, 2'b00};
      REG_DIR:     reg_rd_val = {rot_dir_q, 7'h00};
      REG_FLAGS:   reg_rd_val = {field_high_flag_out, field_low_flag_out, 6'h00};
      default:     reg_rd_val = '0;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      zero_q                 <= ZERO_RESET;
      field_low_threshold_q  <= THR_LOW_RESET;
      field_high_threshold_q <= THR_HIGH_RESET;
      rot_dir_q              <= DIR_RESET;
    end
    else if (cmd_wr) // [RL14] [RL17]
    begin
      if (rx_addr == REG_ZERO_LO)
        zero_q[7:0] <= wr_data;
      if (rx_addr == REG_ZERO_HI)
        zero_q[15:8] <= wr_data;
      if (rx_addr == REG_THRESH)
      begin
        field_low_threshold_q  <= wr_data[THR_LOW_MSB:THR_LOW_LSB];
        field_high_threshold_q <= wr_data[THR_HIGH_MSB:THR_HIGH_LSB];
      end
      if (rx_addr == REG_DIR)
        rot_dir_q <= wr_data[DIR_BIT];
    end
  end

  // SPI frame engine. No timeout in the SPI path, so any slow clock is fine [RL2].
  wire [FRAME_W-1:0] frame_word = reply_pend_q ? {reg_rd_val, 8'h00} :
                                  {obuf_q, {(FRAME_W - ANGLE_W){1'b0}}}; // [RL18] [RL16]
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      bitcnt_q      <= '0;
      reply_pend_q  <= 1'b0;
      reply_addr_q  <= '0;
      miso_out      <= 1'b0;
      miso_oe_out   <= 1'b0;
      spi_mode3_out <= 1'b0;
      rx_q          <= '0;
      tx_q          <= '0;
    end
    else if (cs_fall)
    begin
      bitcnt_q      <= '0; // [RL20]
      tx_q          <= frame_word; // [RL15]
      miso_out      <= frame_word[FRAME_W-1];
      miso_oe_out   <= 1'b1;
      reply_pend_q  <= 1'b0;
      spi_mode3_out <= pin_sync_q[PIN_SCLK]; // [RL1]
    end
    else if (cs_rise)
    begin
      miso_out    <= 1'b0; // [RL13]
      miso_oe_out <= 1'b0;
      if (cmd_rd || cmd_wr)
      begin
        reply_pend_q <= 1'b1; // [RL16] [RL17]
        reply_addr_q <= rx_addr;
      end
    end
    else
    begin
      if (sclk_rise) // [RL4]
      begin
        rx_q     <= {rx_q[FRAME_W-2:0], pin_sync_q[PIN_MOSI]};
        bitcnt_q <= (bitcnt_q == CNT_SAT) ? bitcnt_q : CNT_W'(bitcnt_q + 1'b1);
      end
      // A mode 3 frame opens with a falling edge before any bit; it must not shift.
      if (sclk_fall && (bitcnt_q != '0)) // [RL1] [RL4]
      begin
        tx_q     <= {tx_q[FRAME_W-2:0], 1'b0};
        miso_out <= tx_q[FRAME_W-2];
      end
    end
  end

  // SSI angle readout: falling clock starts, rising edges advance, idle ends it.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      ssi_state_q <= ASP_SSI_IDLE;
      ssi_tx_q    <= '0;
      ssi_tmo_q   <= '0;
      ssd_out     <= 1'b1;
    end
    else
    begin
      unique case (ssi_state_q)
        ASP_SSI_IDLE:
          if (ssck_fall)
          begin
            ssi_state_q <= ASP_SSI_SHIFT;
            ssi_tx_q    <= {obuf_q, {(FRAME_W - ANGLE_W){1'b0}}}; // [RL14] [RL18]
            ssd_out     <= obuf_q[ANGLE_W-1];
            ssi_tmo_q   <= '0;
          end
        ASP_SSI_SHIFT:
          if (ssck_rise)
          begin
            ssi_tx_q  <= {ssi_tx_q[FRAME_W-2:0], 1'b0};
            ssd_out   <= ssi_tx_q[FRAME_W-2];
            ssi_tmo_q <= '0;
          end
          else if (ssck_fall)
            ssi_tmo_q <= '0;
          else if (ssi_tmo_q == SSI_TMO_W'(SSI_TIMEOUT_CYCLES - 1))
          begin
            ssi_state_q <= ASP_SSI_IDLE;
            ssd_out     <= 1'b1;
          end
          else
            ssi_tmo_q <= SSI_TMO_W'(ssi_tmo_q + 1'b1);
      endcase
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_write_frame;
    cmd_wr && (rx_addr == REG_DIR);
  endsequence
  sequence s_dir_reply;
    cs_fall && reply_pend_q && (reply_addr_q == REG_DIR);
  endsequence

  a_miso_idle_low: assert property (!miso_oe_out |-> !miso_out) // [RL13]
    else $error("MISO driven high while released");
  a_miso_release: assert property (cs_rise |=> !miso_oe_out) // [RL13]
    else $error("MISO still enabled after select rose");
  a_buffer_frozen: assert property (!cs_high |=> $stable(obuf_q)) // [RL19]
    else $error("Output buffer changed during a frame");
  a_angle_first: assert property (cs_fall && !reply_pend_q |=>
      miso_oe_out && miso_out == obuf_q[ANGLE_W-1] && tx_q[7:0] == 8'h00) // [RL15]
    else $error("Angle frame did not start with frozen MSB and zero tail");
  a_shift_fall: assert property (sclk_fall && !cs_fall && !cs_rise && bitcnt_q != '0
      |=> miso_out == $past(tx_q[FRAME_W-2])) // [RL4]
    else $error("MISO did not advance on falling clock");
  a_count_restart: assert property (cs_fall |=> bitcnt_q == '0) // [RL20]
    else $error("Bit counter not restarted on select fall");
  a_mode_seen: assert property (cs_fall |=> spi_mode3_out == $past(pin_sync_q[PIN_SCLK])) // [RL1]
    else $error("Clock idle level not captured");
  a_tick_period: assert property (tick_q |-> ##TICK_GAP tick_q) // [RL8]
    else $error("Sample tick period wrong");
  a_low_flag: assert property (field_low_now |=> field_low_flag_out) // [RL11]
    else $error("Low-field flag missing");
  a_high_flag: assert property (field_high_now |=> field_high_flag_out) // [RL12]
    else $error("High-field flag missing");
  a_write_stored: assert property (s_write_frame |=>
      reply_pend_q && rot_dir_q == wr_data[DIR_BIT]) // [RL17]
    else $error("Write did not store the direction or arm the reply");
  a_write_ack: assert property (s_dir_reply |=>
      miso_out == rot_dir_q && tx_q[FRAME_W-1] == rot_dir_q) // [RL17]
    else $error("Write acknowledge does not return stored value");
  a_ssi_start: assert property (ssi_state_q == ASP_SSI_IDLE && ssck_fall |=>
      ssi_busy && ssd_out == obuf_q[ANGLE_W-1]) // [RL14]
    else $error("SSI readout did not start with angle MSB");
endmodule : asp_angle_slave

// [test/asp_spi_master.sv]
// Behavioural SPI master that frames commands towards the angle slave.
`timescale 1ns/1ps
module asp_spi_master (
  input  wire logic        mclk_in,
  input  wire logic        miso_in,
  output logic             sclk_out,
  output logic             cs_n_out,
  output logic             mosi_out,
  output logic             rx_valid_out,
  output logic [15:0]      rx_word_out
);
  initial
  begin
    sclk_out     = 1'b0;
    cs_n_out     = 1'b1;
    mosi_out     = 1'b0;
    rx_valid_out = 1'b0;
    rx_word_out  = 16'h0000;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : wait_clk

  // The link clock rests at the mode's idle level and stands still between frames.
  task automatic frame(input logic mode3, input int nbits, input logic [15:0] tx,
                       input logic chk);
    logic [15:0] rx;
    rx = 16'h0000;
    sclk_out <= mode3;
    wait_clk(1);
    cs_n_out <= 1'b0;
    wait_clk(8);
    for (int i = 0; i < nbits; i++)
    begin
      sclk_out <= 1'b0;
      mosi_out <= tx[15-i];
      wait_clk(4);
      sclk_out <= 1'b1;
      wait_clk(4);
      rx = {rx[14:0], miso_in};
    end
    sclk_out <= mode3;
    wait_clk(4);
    cs_n_out     <= 1'b1;
    mosi_out     <= 1'b0;
    rx_valid_out <= chk;
    rx_word_out  <= rx << (16 - nbits);
    wait_clk(1);
    rx_valid_out <= 1'b0;
    wait_clk(40);
  endtask : frame
endmodule : asp_spi_master

// [test/tb_asp_angle_slave.sv]
// Self-checking bench for the angle sensor serial slave.
`timescale 1ns/1ps
module tb_asp_angle_slave;
  import asp_pkg::*;
  logic               mclk_in;
  logic               reset_in;
  logic [ANGLE_W-1:0] raw_angle_in;
  logic [ANGLE_W-1:0] field_strength_in;
  logic               sclk, cs_n, mosi, ssck, miso_out, miso_oe_out, ssd_out, miso_wire;
  logic               field_low_flag_out, field_high_flag_out, spi_mode3_out;
  logic               rx_valid, ssi_valid;
  logic [15:0]        rx_word, ssi_word, lfsr_q;
  logic [15:0]        exp_q[$];
  logic [7:0]         a;
  int                 n_errors, n_tests, cycles;

  // The model stores a write at once, so the bench shortens the nonvolatile write wait.
  localparam int NONVOLATILE_WRITE_WAIT = 1000;

  initial
  begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  asp_angle_slave uut (
    .mclk_in             (mclk_in),
    .reset_in            (reset_in),
    .raw_angle_in        (raw_angle_in),
    .field_strength_in   (field_strength_in),
    .sclk_in             (sclk),
    .cs_n_in             (cs_n),
    .mosi_in             (mosi),
    .ssck_in             (ssck),
    .miso_out            (miso_out),
    .miso_oe_out         (miso_oe_out),
    .ssd_out             (ssd_out),
    .field_low_flag_out  (field_low_flag_out),
    .field_high_flag_out (field_high_flag_out),
    .spi_mode3_out       (spi_mode3_out)
  );

  asp_spi_master master (
    .mclk_in      (mclk_in),
    .miso_in      (miso_wire),
    .sclk_out     (sclk),
    .cs_n_out     (cs_n),
    .mosi_out     (mosi),
    .rx_valid_out (rx_valid),
    .rx_word_out  (rx_word)
  );

  // The pull-down pulls the released data line low.
  assign miso_wire = miso_oe_out ? miso_out : 1'b0;

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  task automatic check(input string what, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, ex, got);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  always @(posedge mclk_in)
  begin
    if (rx_valid === 1'b1)
      check("spi word", exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, rx_word);
    if (ssi_valid === 1'b1)
      check("ssi word", exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, ssi_word);
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic spi(input logic m3, input logic [15:0] tx, input logic chk,
                     input logic [15:0] ex);
    if (chk)
      exp_q.push_back(ex);
    master.frame(m3, 16, tx, chk);
  endtask : spi

  // Waits long enough that fresh samples have flushed the small sample buffer.
  task automatic rd_angle(input logic m3, input logic [7:0] v);
    repeat (300) @(posedge mclk_in);
    spi(m3, 16'h0000, 1'b1, {v, 8'h00});
  endtask : rd_angle

  task automatic wr(input logic m3, input logic [4:0] addr, input logic [7:0] d);
    spi(m3, {CMD_WRITE, addr, d}, 1'b0, 16'h0000);
    repeat (NONVOLATILE_WRITE_WAIT) @(posedge mclk_in);
    spi(m3, 16'h0000, 1'b1, {d, 8'h00});
  endtask : wr

  task automatic rd(input logic m3, input logic [4:0] addr, input logic [7:0] d);
    spi(m3, {CMD_READ, addr, 8'h00}, 1'b0, 16'h0000);
    spi(m3, 16'h0000, 1'b1, {d, 8'h00});
  endtask : rd

  task automatic flags(input logic [2:0] lo, input logic [2:0] hi);
    for (int i = 0; i < 32; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      field_strength_in <= lfsr_q[7:0];
      repeat (3) @(posedge mclk_in);
      check("low flag", {15'h0, lfsr_q[7:5] < lo}, {15'h0, field_low_flag_out});
      check("high flag", {15'h0, lfsr_q[7:5] > hi}, {15'h0, field_high_flag_out});
    end
  endtask : flags

  task automatic ssi_read(input logic [15:0] ex);
    logic [15:0] w;
    w = 16'h0000;
    exp_q.push_back(ex);
    for (int i = 0; i < 16; i++)
    begin
      ssck <= 1'b0;
      repeat (8) @(posedge mclk_in);
      w = {w[14:0], ssd_out};
      ssck <= 1'b1;
      repeat (8) @(posedge mclk_in);
    end
    ssi_word  <= w;
    ssi_valid <= 1'b1;
    @(posedge mclk_in);
    ssi_valid <= 1'b0;
    repeat (1300) @(posedge mclk_in);
  endtask : ssi_read

  initial
  begin
    n_errors = 0;
    n_tests = 0;
    cycles = 0;
    ssck = 1'b1;
    ssi_valid = 1'b0;
    ssi_word = 16'h0000;
    lfsr_q = lfsr_next(16'h0012);
    a = lfsr_q[7:0];
    raw_angle_in = a;
    field_strength_in = 8'h00;
    reset_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    check("idle miso", 16'h0000, {14'h0, miso_oe_out, miso_wire});
    check("idle ssd", 16'h0001, {15'h0, ssd_out});
    rd_angle(1'b0, a);
    check("mode flag", 16'h0000, {15'h0, spi_mode3_out});
    check("released miso", 16'h0000, {14'h0, miso_oe_out, miso_wire});
    rd_angle(1'b1, a);
    check("mode flag", 16'h0001, {15'h0, spi_mode3_out});
    master.frame(1'b1, 8, {CMD_READ, REG_THRESH, 8'h00}, 1'b0);
    rd_angle(1'b0, a);
    rd(1'b0, REG_THRESH, {THR_LOW_RESET, THR_HIGH_RESET, 2'b00});
    rd(1'b1, REG_DIR, {DIR_RESET, 7'h00});
    flags(THR_LOW_RESET, THR_HIGH_RESET);
    wr(1'b1, REG_THRESH, 8'h94);
    flags(3'h4, 3'h5);
    field_strength_in <= 8'hFF;
    rd(1'b0, REG_FLAGS, 8'h80);
    wr(1'b0, REG_DIR, 8'h80);
    rd_angle(1'b0, 8'h00 - a);
    wr(1'b1, REG_ZERO_HI, 8'h10);
    rd_angle(1'b1, 8'h10 - a);
    wr(1'b0, REG_ZERO_LO, 8'h01);
    repeat (300) @(posedge mclk_in);
    ssi_read({8'h10 - a, 8'h00});
    check("ssd after timeout", 16'h0001, {15'h0, ssd_out});
    summarize();
  end
endmodule : tb_asp_angle_slave
